/* File: verif/tb_cascadable_timers.sv */
// Self-checking testbench for the cascadable timer block
module tb_cascadable_timers;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 60000;
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [11:0] s_axi_awaddr  = '0;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata   = '0;
  logic [3:0]  s_axi_wstrb   = 4'hf;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready  = 1'b0;
  logic [11:0] s_axi_araddr  = '0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready  = 1'b0;
  logic [3:0]  timer_irq;
  logic        timer_toggle_output;
  logic        port_b_line_one_out;
  logic        port_b_line_one_oe;
  int          miscompares     = 0;
  int          samples_checked = 0;
  int          cyc             = 0;
  int          seed            = 32;
  int          irq_q[4][$];
  logic [31:0] rd;
  logic [1:0]  rs;
  int          r, t, b0, b1;

  cascadable_timers i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_irq(timer_irq), .timer_toggle_output(timer_toggle_output),
    .port_b_line_one_out(port_b_line_one_out), .port_b_line_one_oe(port_b_line_one_oe));

  ////////////////////////////////////////////////////////////////////////////////
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      miscompares++;
      finish_test();
    end
  end
  // Interrupt pulse log, sampled mid-cycle
  always @(negedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (timer_irq[i] === 1'b1) irq_q[i].push_back(cyc);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic aw_done, w_done, aw_hs, w_hs, b_hs;
    aw_done = 1'b0;
    w_done  = 1'b0;
    b_hs    = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs  = s_axi_wvalid && s_axi_wready;
      @(posedge aclk);
      if (aw_hs) begin
        s_axi_awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (w_hs) begin
        s_axi_wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (!b_hs) begin
      @(negedge aclk);
      b_hs = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
    end
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ar_hs, r_hs;
    ar_hs = 1'b0;
    r_hs  = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r_hs) begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs  = s_axi_rvalid;
      d     = s_axi_rdata;
      resp  = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [1:0] resp;
    axi_write(a, d, resp);
    check("bresp", {30'h0, resp}, {30'h0, timer_pkg::RESP_OKAY});
  endtask : wr

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  resp;
    axi_read(a, d, resp);
    check(name, d, exp);
  endtask : rd_chk

  task automatic wait_n(input int b, input int n);
    while (irq_q[b].size() < n) @(negedge aclk);
  endtask : wait_n

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state of control, count and status registers and interrupt outputs, then an unmapped read
    rd_chk("ctrl", timer_pkg::CTRL_ADDR, 32'h0000_0000);
    for (int i = 0; i < 4; i++) rd_chk("cnt", timer_pkg::CNT_BASE + 12'(4 * i), 32'h0000_0000);
    rd_chk("stat", timer_pkg::STAT_ADDR, 32'h0000_0000);
    check("irq", {28'h0, timer_irq}, 32'h0000_0000);
    axi_read(12'h0fc, rd, rs);
    check("unmapped", {rd[29:0], rs}, {30'h0, timer_pkg::RESP_SLVERR});
    // Count and reload registers hold a byte, upper bits read zero
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      wr(timer_pkg::RLO_BASE + 12'(4 * (i % 4)) + ((i > 3) ? 12'h010 : 12'h000), r);
      rd_chk("reload", timer_pkg::RLO_BASE + 12'(4 * (i % 4)) + ((i > 3) ? 12'h010 : 12'h000),
             {24'h0, 8'(r)});
      wr(timer_pkg::CNT_BASE + 12'(4 * (i % 4)), r);
      rd_chk("count", timer_pkg::CNT_BASE + 12'(4 * (i % 4)), {24'h0, 8'(r)});
    end
    // Port pin enable needs both direction and special function bit one
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(timer_pkg::PB_DIR_ADDR, {24'h0, 8'(r)});
      wr(timer_pkg::PB_SFR_ADDR, {24'h0, 8'(r >> 8)});
      rd_chk("pb_dir", timer_pkg::PB_DIR_ADDR, {24'h0, 8'(r)});
      check("pb_oe", {31'h0, port_b_line_one_oe}, {31'h0, r[1] & r[9]});
    end
    wr(timer_pkg::PB_DIR_ADDR, 32'h0000_0002);
    wr(timer_pkg::PB_SFR_ADDR, 32'h0000_0002);
    check("pb_oe", {31'h0, port_b_line_one_oe}, 32'h0000_0001);
    // Auto-reload timer a0 with single-shot a1 beside it
    r = 3 + ($unsigned($random(seed)) % 8);
    wr(timer_pkg::RLO_BASE, r);
    wr(timer_pkg::CNT_BASE, r);
    wr(timer_pkg::RLO_BASE + 12'h004, 32'h0000_0064);
    wr(timer_pkg::CNT_BASE + 12'h004, 32'h0000_0004);
    b0 = irq_q[0].size();
    b1 = irq_q[1].size();
    wr(timer_pkg::CTRL_ADDR, 32'h0000_0023);
    t = cyc;
    wait_n(1, b1 + 1);
    check("a1_first", (irq_q[1][b1] - t >= 20) && (irq_q[1][b1] - t <= 36), 1);
    for (int k = 1; k <= 3; k++) begin
      wait_n(0, b0 + k + 1);
      check("toggle", {31'h0, timer_toggle_output}, 32'(irq_q[0].size() % 2));
      check("pin", {31'h0, port_b_line_one_out}, 32'(irq_q[0].size() % 2));
      axi_read(timer_pkg::CNT_BASE, rd, rs);
      check("a0_period", irq_q[0][b0 + k] - irq_q[0][b0 + k - 1], 8 * r);
    end
    rd_chk("ctrl_a1_clr", timer_pkg::CTRL_ADDR, 32'h0000_0021);
    rd_chk("a1_stop", timer_pkg::CNT_BASE + 12'h004, 32'h0000_0000);
    check("irq1_once", irq_q[1].size(), b1 + 1);
    // New reload value takes effect at the next zero
    b0 = irq_q[0].size();
    wr(timer_pkg::RLO_BASE, 32'h0000_0005);
    wait_n(0, b0 + 2);
    check("new_reload", irq_q[0][b0 + 1] - irq_q[0][b0], 40);
    // Count written while running, single shot
    wr(timer_pkg::CTRL_ADDR, 32'h0000_0000);
    wr(timer_pkg::CNT_BASE, 32'h0000_00c8);
    b0 = irq_q[0].size();
    wr(timer_pkg::CTRL_ADDR, 32'h0000_0001);
    repeat (40) @(posedge aclk);
    wr(timer_pkg::CNT_BASE, 32'h0000_0003);
    t = cyc;
    wait_n(0, b0 + 1);
    check("cnt_wr", (irq_q[0][b0] - t >= 12) && (irq_q[0][b0] - t <= 28), 1);
    rd_chk("ctrl_a0_clr", timer_pkg::CTRL_ADDR, 32'h0000_0000);
    // Cascaded pair b, low byte in the even timer
    wr(timer_pkg::RLO_BASE + 12'h008, 32'h0000_0003);
    wr(timer_pkg::RLO_BASE + 12'h00c, 32'h0000_0001);
    wr(timer_pkg::CNT_BASE + 12'h008, 32'h0000_0003);
    wr(timer_pkg::CNT_BASE + 12'h00c, 32'h0000_0001);
    b0 = irq_q[2].size();
    b1 = irq_q[0].size();
    wr(timer_pkg::CTRL_ADDR, 32'h0000_0004);
    wait_n(2, b0 + 3);
    check("b_period", irq_q[2][b0 + 2] - irq_q[2][b0 + 1], 8 * 259);
    check("irq3_none", irq_q[3].size(), 0);
    check("timer_a_interrupt_request_none", irq_q[0].size(), b1);
    // Standard cascade on pair a, odd byte high, even interrupt only
    wr(timer_pkg::CTRL_ADDR, 32'h0000_0000);
    wr(timer_pkg::RLO_BASE + 12'h004, 32'h0000_0001);
    wr(timer_pkg::CNT_BASE, 32'h0000_0005);
    wr(timer_pkg::CNT_BASE + 12'h004, 32'h0000_0000);
    b0 = irq_q[0].size();
    b1 = irq_q[1].size();
    wr(timer_pkg::CTRL_ADDR, 32'h0000_0009);
    wait_n(0, b0 + 2);
    check("a16_period", irq_q[0][b0 + 1] - irq_q[0][b0], 8 * 261);
    check("a16_irq1_none", irq_q[1].size(), b1);
    // PWM on pair a, counts preloaded with the high phase
    wr(timer_pkg::CTRL_ADDR, 32'h0000_0000);
    wr(timer_pkg::RLO_BASE, 32'h0000_0002);
    wr(timer_pkg::RLO_BASE + 12'h004, 32'h0000_0001);
    wr(timer_pkg::RHI_BASE, 32'h0000_0001);
    wr(timer_pkg::RHI_BASE + 12'h004, 32'h0000_0002);
    wr(timer_pkg::CNT_BASE, 32'h0000_0001);
    wr(timer_pkg::CNT_BASE + 12'h004, 32'h0000_0002);
    b0 = irq_q[0].size();
    b1 = irq_q[1].size();
    wr(timer_pkg::CTRL_ADDR, 32'h0000_0019);
    wait_n(1, b1 + 2);
    wait_n(0, b0 + 2);
    check("pwm_first", irq_q[1][b1] < irq_q[0][b0], 1);
    check("pwm_low", irq_q[0][b0] - irq_q[1][b1], 8 * 258);
    check("pwm_high", irq_q[1][b1 + 1] - irq_q[0][b0], 8 * 513);
    check("pwm_low2", irq_q[0][b0 + 1] - irq_q[1][b1 + 1], 8 * 258);
    check("pwm_tgl", {31'h0, timer_toggle_output}, 32'(irq_q[0].size() % 2));
    finish_test();
  end
endmodule : tb_cascadable_timers

/* File: verilog/cascadable_timers.sv */
// Four 8-bit down timers with cascading, PWM and toggle output behind an AXI4-Lite slave
//
// What this block does
// - Each 8-bit timer has a readable, writable reload register and count register.
// - Enabled timer counts down to zero, interrupts, and reloads when auto-init set.
// - Single-shot timer stops at zero and hardware clears its enable bit.
// - Software write to a running count makes counting continue from that value.
// - Reload written while active is used at the next zero.
// - Software write beats decrementer writeback; single-shot clear beats software write.
// - Reading count or reload registers never disturbs the timer.
// - Cascaded pair outside PWM interrupts once, on full 16-bit zero, via the even timer.
// - In a cascaded pair the even timer holds the low byte.
// - Cascaded timers always reload and keep running while interrupts are pending.
// - A second timeout before service need not be detected.
// - Enabling a timer starts counting from its count value, no reload first.
// - Timers use only an internal clock, stepping once per eight clocks.
// - Independent first pair: two 8-bit timers, own reload, own interrupt.
// - Second pair works only as one cascaded 16-bit standard timer.
// - PWM uses low-phase and high-phase 16-bit reload pairs, odd byte high.
// - PWM reloads alternate low then high phase, starting with low.
// - PWM first timeout raises the odd interrupt and reloads the low phase.
// - Low phase expiry raises even interrupt, high phase expiry raises odd.
// - Each timer0 timeout toggles the flip-flop driving the toggle output pin.
// - Constant reload continuous timer0 gives an equal high and low square wave.
// - Reset leaves every timer disabled.
module cascadable_timers (
  input  wire  logic        aclk,
  input  wire  logic        aresetn,
  input  wire  logic [11:0] s_axi_awaddr,
  input  wire  logic        s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire  logic [31:0] s_axi_wdata,
  input  wire  logic [3:0]  s_axi_wstrb,
  input  wire  logic        s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire  logic        s_axi_bready,
  input  wire  logic [11:0] s_axi_araddr,
  input  wire  logic        s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire  logic        s_axi_rready,
  output logic [3:0]        timer_irq,
  output logic              timer_toggle_output,
  output logic              port_b_line_one_out,
  output logic              port_b_line_one_oe
);

  function automatic logic [15:0] dec16(input logic [15:0] v);
    return v - 16'h0001;
  endfunction : dec16

  timer_pkg::ctrl_t ctrl;
  timer_pkg::ctrl_t next_ctrl;
  logic [7:0]       cnt [4];
  logic [7:0]       next_cnt [4];
  logic [7:0]       rlo [4];
  logic [7:0]       rhi [2];
  logic [7:0]       pb_dir;
  logic [7:0]       pb_sfr;
  logic [2:0]       prescale;
  logic             tick;
  logic             pwm_phase;
  logic             next_phase;
  logic             toggle;
  logic [3:0]       ev;
  logic [1:0]       clr;
  logic             aw_held;
  logic             w_held;
  logic [11:0]      awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             do_wr;
  logic             wr_ok;
  logic [31:0]      rd_data;
  logic             rd_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prescale <= 3'h0;
    end else begin
      prescale <= prescale + 3'h1;
    end
  end
  assign tick = (prescale == timer_pkg::PRESCALE_TOP);

  ////////////////////////////////////////////////////////////////////////////
  // Countdown engines
  always_comb begin
    logic [15:0] v;
    v = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      next_cnt[i] = cnt[i];
    end
    ev         = 4'h0;
    clr        = 2'b00;
    next_phase = pwm_phase;
    if (tick) begin
      if (ctrl.casc_a) begin
        if (ctrl.en_a0) begin
          v = dec16({cnt[1], cnt[0]});
          if (v == 16'h0000) begin
            if (ctrl.pwm && !pwm_phase) begin
              ev[1]      = 1'b1;
              v          = {rlo[1], rlo[0]};
              next_phase = 1'b1;
            end else if (ctrl.pwm) begin
              ev[0]      = 1'b1;
              v          = {rhi[1], rhi[0]};
              next_phase = 1'b0;
            end else begin
              ev[0] = 1'b1;
              v     = {rlo[1], rlo[0]};
            end
          end
          next_cnt[0] = v[7:0];
          next_cnt[1] = v[15:8];
        end
      end else begin
        for (int i = 0; i < 2; i++) begin
          if ((i == 0) ? ctrl.en_a0 : ctrl.en_a1) begin
            next_cnt[i] = cnt[i] - 8'h01;
            if (next_cnt[i] == 8'h00) begin
              ev[i] = 1'b1;
              if ((i == 0) ? ctrl.auto_a0 : ctrl.auto_a1) begin
                next_cnt[i] = rlo[i];
              end else begin
                clr[i] = 1'b1;
              end
            end
          end
        end
      end
      if (ctrl.en_b) begin
        v = dec16({cnt[3], cnt[2]});
        if (v == 16'h0000) begin
          ev[2] = 1'b1;
          v     = {rlo[3], rlo[2]};
        end
        next_cnt[2] = v[7:0];
        next_cnt[3] = v[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count registers, software write has priority
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!aresetn) begin
        cnt[i] <= timer_pkg::CNT_RST;
      end else if (do_wr && wstrb_q[0] && awaddr_q == timer_pkg::CNT_BASE + 12'(4 * i)) begin
        cnt[i] <= wdata_q[7:0];
      end else begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // Reload registers
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (!aresetn) begin
        rlo[i] <= timer_pkg::CNT_RST;
      end else if (do_wr && wstrb_q[0] && awaddr_q == timer_pkg::RLO_BASE + 12'(4 * i)) begin
        rlo[i] <= wdata_q[7:0];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (!aresetn) begin
        rhi[i] <= timer_pkg::CNT_RST;
      end else if (do_wr && wstrb_q[0] && awaddr_q == timer_pkg::RHI_BASE + 12'(4 * i)) begin
        rhi[i] <= wdata_q[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and PWM phase
  always_comb begin
    next_ctrl = ctrl;
    if (do_wr && wstrb_q[0] && awaddr_q == timer_pkg::CTRL_ADDR) begin
      next_ctrl = timer_pkg::ctrl_t'(wdata_q[6:0]);
    end
    if (clr[0]) begin
      next_ctrl.en_a0 = 1'b0;
    end
    if (clr[1]) begin
      next_ctrl.en_a1 = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= timer_pkg::ctrl_t'(timer_pkg::CTRL_RST);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_phase <= 1'b0;
    end else if (next_ctrl.en_a0 && !ctrl.en_a0) begin
      pwm_phase <= 1'b0;
    end else begin
      pwm_phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt pulses, toggle and port B pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 4'h0;
      toggle    <= 1'b0;
    end else begin
      timer_irq <= ev;
      if (ev[0]) begin
        toggle <= !toggle;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_dir <= timer_pkg::PB_RST;
      pb_sfr <= timer_pkg::PB_RST;
    end else if (do_wr && wstrb_q[0]) begin
      if (awaddr_q == timer_pkg::PB_DIR_ADDR) begin
        pb_dir <= wdata_q[7:0];
      end
      if (awaddr_q == timer_pkg::PB_SFR_ADDR) begin
        pb_sfr <= wdata_q[7:0];
      end
    end
  end

  assign timer_toggle_output = toggle;
  assign port_b_line_one_out = toggle;
  assign port_b_line_one_oe  = pb_dir[timer_pkg::TIMER_TOGGLE_OUTPUT_BIT] && pb_sfr[timer_pkg::TIMER_TOGGLE_OUTPUT_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign do_wr         = aw_held && w_held && !s_axi_bvalid;

  always_comb begin
    wr_ok = 1'b0;
    if (awaddr_q == timer_pkg::CTRL_ADDR || awaddr_q == timer_pkg::PB_DIR_ADDR) begin
      wr_ok = 1'b1;
    end else if (awaddr_q == timer_pkg::PB_SFR_ADDR) begin
      wr_ok = 1'b1;
    end else if (awaddr_q[11:4] == timer_pkg::CNT_BASE[11:4] && awaddr_q[1:0] == 2'b00) begin
      wr_ok = 1'b1;
    end else if (awaddr_q[11:4] == timer_pkg::RLO_BASE[11:4] && awaddr_q[1:0] == 2'b00) begin
      wr_ok = 1'b1;
    end else if (awaddr_q == timer_pkg::RHI_BASE || awaddr_q == timer_pkg::RHI_BASE + 12'h004) begin
      wr_ok = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      awaddr_q     <= 12'h000;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= timer_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held) begin
        aw_held  <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
        w_held  <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, side-effect free
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr == timer_pkg::CTRL_ADDR) begin
      rd_data[6:0] = ctrl;
    end else if (s_axi_araddr == timer_pkg::STAT_ADDR) begin
      rd_data[1:0] = timer_pkg::stat_t'({pwm_phase, toggle});
    end else if (s_axi_araddr == timer_pkg::PB_DIR_ADDR) begin
      rd_data[7:0] = pb_dir;
    end else if (s_axi_araddr == timer_pkg::PB_SFR_ADDR) begin
      rd_data[7:0] = pb_sfr;
    end else if (s_axi_araddr[11:4] == timer_pkg::CNT_BASE[11:4] && s_axi_araddr[1:0] == 2'b00) begin
      rd_data[7:0] = cnt[s_axi_araddr[3:2]];
    end else if (s_axi_araddr[11:4] == timer_pkg::RLO_BASE[11:4] && s_axi_araddr[1:0] == 2'b00) begin
      rd_data[7:0] = rlo[s_axi_araddr[3:2]];
    end else if (s_axi_araddr == timer_pkg::RHI_BASE || s_axi_araddr == timer_pkg::RHI_BASE + 12'h004) begin
      rd_data[7:0] = rhi[s_axi_araddr[2]];
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= timer_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_ok ? timer_pkg::RESP_OKAY : timer_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  a_tick_every_eight: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> !tick [*7] ##1 tick) else $error("tick spacing is not eight clocks");

  a_single_shot_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    clr[0] |=> !ctrl.en_a0) else $error("single-shot enable not cleared");

  a_sw_write_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_wr && wstrb_q[0] && awaddr_q == timer_pkg::CNT_BASE) |=> cnt[0] == $past(wdata_q[7:0]))
    else $error("count write lost to decrement");

  a_toggle_on_timeout: assert property (@(posedge aclk) disable iff (!aresetn)
    timer_irq[0] |-> toggle != $past(toggle)) else $error("toggle output missed a timeout");

  a_odd_b_silent: assert property (@(posedge aclk) disable iff (!aresetn)
    !timer_irq[3]) else $error("odd timer of second pair interrupted");

  a_reset_disables: assert property (@(posedge aclk)
    !aresetn |=> !ctrl.en_a0 && !ctrl.en_a1 && !ctrl.en_b) else $error("timer enabled after reset");

  a_pwm_alternates: assert property (@(posedge aclk) disable iff (!aresetn)
    (ev[1] && ctrl.pwm && ctrl.casc_a) |=> pwm_phase && timer_irq[1] && {cnt[1], cnt[0]} == $past({rlo[1], rlo[0]})
    || $past(do_wr)) else $error("pwm did not reload low phase");

  a_count_on_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tick && !do_wr) |=> cnt[0] == $past(cnt[0])) else $error("count moved without a tick");

endmodule : cascadable_timers

/* File: verilog/timer_pkg.sv */
// Package with register map, control fields and timing constants of the timer block
package timer_pkg;
  localparam int             ADDR_W       = 12;
  localparam logic [11:0]    CTRL_ADDR    = 12'h000;
  localparam logic [11:0]    CNT_BASE     = 12'h010;
  localparam logic [11:0]    RLO_BASE     = 12'h020;
  localparam logic [11:0]    RHI_BASE     = 12'h030;
  localparam logic [11:0]    STAT_ADDR    = 12'h040;
  localparam logic [7:0]     PB_DIR_IDX   = 8'hd6;
  localparam logic [7:0]     PB_SFR_IDX   = 8'hd7;
  localparam logic [11:0]    PB_DIR_ADDR  = {2'b00, PB_DIR_IDX, 2'b00};
  localparam logic [11:0]    PB_SFR_ADDR  = {2'b00, PB_SFR_IDX, 2'b00};
  localparam int             TIMER_TOGGLE_OUTPUT_BIT     = 1;
  localparam int             PRESCALE_DIV = 8;
  localparam logic [2:0]     PRESCALE_TOP = 3'(PRESCALE_DIV - 1);
  localparam logic [6:0]     CTRL_RST     = 7'h00;
  localparam logic [7:0]     PB_RST       = 8'h00;
  localparam logic [7:0]     CNT_RST      = 8'h00;
  localparam logic [1:0]     RESP_OKAY    = 2'b00;
  localparam logic [1:0]     RESP_SLVERR  = 2'b10;

  // Control register, bit 0 is en_a0
  typedef struct packed {
    logic auto_a1;
    logic auto_a0;
    logic pwm;
    logic casc_a;
    logic en_b;
    logic en_a1;
    logic en_a0;
  } ctrl_t;

  // Status register, bit 0 is toggle
  typedef struct packed {
    logic pwm_phase;
    logic toggle;
  } stat_t;
endpackage : timer_pkg
